// ===== dv/lintm_bus_model.sv
// shared single-wire bus: far-side node plus termination pull-up
`timescale 1ns/1ns
module lintm_bus_model (
  input  wire logic i_dev_oe_n,
  input  wire logic i_remote_dom,
  output logic      o_bus
);
  // wired-and: any driver pulls dominant, else the pull-up wins
  assign o_bus = i_dev_oe_n & ~i_remote_dom;
endmodule

// ===== dv/testbench.sv
// scenario testbench for the lin transceiver control logic
`timescale 1ns/1ns
module testbench;
  import lintm_pkg::*;
  localparam int unsigned DOM_TO = 2500;
  localparam int unsigned STUCK  = 3000;
  localparam int unsigned PWRUP  = 50;
  logic           clk;
  logic           rst_n;
  logic           bus_oe_n;
  logic           rxd_o;
  logic           rxd_oe_n;
  logic           bus;
  logic           rxd;
  logic           remote_dom;
  lintm_host_in_t host;
  lintm_mode_t    mode;
  lintm_stat_t    stat;
  int             fail_count;
  int             num_checks;

  lintm_core #(.DOM_TO_CYCLES(DOM_TO), .STUCK_CYCLES(STUCK), .PWRUP_CYCLES(PWRUP)) DUT (
    .i_clk(clk), .i_rst_n(rst_n), .i_host(host), .i_bus_in(bus), .o_bus_oe_n(bus_oe_n),
    .o_rxd_o(rxd_o), .o_rxd_oe_n(rxd_oe_n), .o_mode(mode), .o_stat(stat));
  lintm_bus_model u_bus (.i_dev_oe_n(bus_oe_n), .i_remote_dom(remote_dom), .o_bus(bus));
  // open-drain rxd with host-side pull-up
  assign rxd = rxd_oe_n ? 1'b1 : rxd_o;

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic tick(input int n = 1);
    repeat (n) begin
      @(posedge clk);
      #5;
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [2:0] exp, input logic [2:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  function automatic logic sel(input int which);
    case (which)
      0: sel = (mode === LINTM_NORMAL);
      1: sel = (mode === LINTM_SLEEP);
      2: sel = (mode === LINTM_STANDBY);
      3: sel = stat.rx_valid;
      4: sel = stat.dom_timeout;
      default: sel = stat.wake_lockout;
    endcase
  endfunction

  // bounded wait; the cycle count must land inside [lo, hi]
  task automatic wait_sig(input string name, input int which, input logic val,
                          input int lo, input int hi);
    int n;
    n = 0;
    while (sel(which) !== val && n <= hi) begin
      tick();
      n++;
    end
    num_checks++;
    if (n < lo || n > hi) begin
      fail_count++;
      $display("[ERR] %s expected %0d..%0d cycles seen %0d", name, lo, hi, n);
      if (n > hi) summarize();
    end
  endtask

  task automatic t_reset_vals();
    chk("reset", {2'(LINTM_SLEEP), 1'b1}, {mode, bus_oe_n});
    chk("reset_stat", 3'h0, stat);
    chk("reset_rxd", 3'h1, {2'h0, rxd});
  endtask

  task automatic t_wake_en();
    host.en = 1'b1;
    wait_sig("sleep_to_normal", 0, 1'b1, 40, 300);
    wait_sig("normal_init", 3, 1'b1, 0, 600);
  endtask

  task automatic t_stream();
    logic [7:0] pat;
    pat = 8'hA5;
    for (int i = 0; i < 8; i++) begin
      host.txd = pat[i];
      tick(2);
      chk("tx_path", {2'h0, pat[i]}, {2'h0, bus_oe_n});
      chk("rx_path", {2'h0, pat[i]}, {2'h0, rxd});
      tick(998);
    end
    // remote node at 100 kbps; rx_valid must not drop with the bus
    for (int i = 0; i < 4; i++) begin
      remote_dom = ~i[0];
      tick(2);
      chk("rx_remote", {2'h3, i[0]}, {stat.rx_valid, bus_oe_n, rxd});
      tick(198);
    end
  endtask

  task automatic t_dom_to();
    host.txd = 1'b0;
    wait_sig("dom_timeout", 4, 1'b1, DOM_TO - 5, DOM_TO + 5);
    tick();
    chk("dto_driver", {2'(LINTM_NORMAL), 1'b1}, {mode, bus_oe_n});
    remote_dom = 1'b1;
    tick(2);
    chk("dto_rx", 3'h0, {2'h0, rxd});
    remote_dom = 1'b0;
    host.txd = 1'b1;
    tick(2);
    chk("dto_clear", 3'h1, {1'b0, stat.dom_timeout, bus_oe_n});
  endtask

  task automatic t_sleep();
    host.en = 1'b0;
    wait_sig("normal_to_sleep", 1, 1'b1, 40, 300);
    host.txd = 1'b0;
    tick(3);
    chk("sleep_paths", 3'h3, {1'b0, bus_oe_n, rxd});
    host.txd = 1'b1;
  endtask

  task automatic t_bus_wake();
    remote_dom = 1'b1;
    tick(400);
    remote_dom = 1'b0;
    tick(3);
    chk("short_dom", {2'(LINTM_SLEEP), 1'b0}, {mode, 1'b0});
    remote_dom = 1'b1;
    wait_sig("bus_wake", 2, 1'b1, 500, 3000);
    remote_dom = 1'b0;
    tick(2);
    chk("standby_rxd", 3'h0, {2'h0, rxd});
    host.en = 1'b1;
    wait_sig("standby_to_normal", 0, 1'b1, 40, 300);
    t_sleep();
  endtask

  task automatic t_lockout();
    remote_dom = 1'b1;
    wait_sig("lockout_set", 5, 1'b1, 0, STUCK + 500);
    remote_dom = 1'b0;
    wait_sig("lockout_clear", 5, 1'b0, 160, 1000);
  endtask

  initial begin
    fail_count = 0;
    num_checks = 0;
    rst_n = 1'b0;
    host.en = 1'b0;
    host.txd = 1'b1;
    remote_dom = 1'b0;
    tick(12);
    rst_n = 1'b1;
    tick();
    t_reset_vals();
    t_wake_en();
    t_stream();
    t_dom_to();
    t_sleep();
    t_bus_wake();
    t_lockout();
    summarize();
  end
endmodule

// ===== logic/lintm_core.sv
// lin transceiver control: modes, wake qualification, dominant timeout, rx gating
`timescale 1ns/1ns
// How it works
// - in low power, bus wake needs continuous dominant for 25 to 150 us.
// - after stuck-dominant lockout, re-arm wake once recessive 8 to 50 us.
// - transmit dominant timeout expires between 20 and 80 ms, nominally 34.
// - falling txd starts timer; expiry disables driver; rising txd clears it.
// - standby to normal, or normal to sleep, completes in 2 to 15 us.
// - after entering normal, rx data is valid within 30 us.
// - sleep to normal takes mode change plus init; host waits both.
// - after power-up, rx output is valid within 1.5 ms.
// - host supplies bit stream on txd; device drives it onto the bus.
// - txd low drives dominant, high recessive; unconnected txd reads low.
// - received bus level is delivered to the host on rxd.
// - normal: rxd follows bus; standby: rxd held low for wake request.
// - bus has two states only: dominant and recessive.
// - wake sources are the enable input and qualified bus dominant.
// - enable high means normal with both paths; low means sleep, none.
// - receive path follows bus transitions up to 100 kbps.
module lintm_core
  import lintm_pkg::*;
#(
  parameter int unsigned DOM_TO_CYCLES = DOM_TO_CYC,
  parameter int unsigned STUCK_CYCLES  = STUCK_DOM_CYC,
  parameter int unsigned PWRUP_CYCLES  = PWRUP_CYC
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_n,
  input  wire lintm_pkg::lintm_host_in_t i_host,
  input  wire logic                     i_bus_in,
  output logic                          o_bus_oe_n,
  output logic                          o_rxd_o,
  output logic                          o_rxd_oe_n,
  output lintm_pkg::lintm_mode_t        o_mode,
  output lintm_pkg::lintm_stat_t        o_stat
);
  import lintm_pkg::*;

  // wake qualify must finish below the stuck threshold, or bus wake is lost
  if (DOM_TO_CYCLES < 2 || DOM_TO_CYCLES >= (1 << CNT_W) ||
      STUCK_CYCLES < 2 || STUCK_CYCLES >= (1 << CNT_W) ||
      STUCK_CYCLES <= WAKE_QUAL_CYC ||
      PWRUP_CYCLES < 2 || PWRUP_CYCLES >= (1 << CNT_W)) begin : g_chk
    $error("lintm_core: count parameter out of range");
  end

  localparam logic [CNT_W-1:0] DOM_TO_C = CNT_W'(DOM_TO_CYCLES);
  localparam logic [CNT_W-1:0] STUCK_C  = CNT_W'(STUCK_CYCLES);
  localparam logic [CNT_W-1:0] PWRUP_C  = CNT_W'(PWRUP_CYCLES);
  localparam logic [CNT_W-1:0] WQ_C     = CNT_W'(WAKE_QUAL_CYC);
  localparam logic [CNT_W-1:0] CLR_C    = CNT_W'(CLEAR_CYC);
  localparam logic [CNT_W-1:0] MC_C     = CNT_W'(MODE_CHG_CYC);
  localparam logic [CNT_W-1:0] NI_C     = CNT_W'(NORM_INIT_CYC);
  localparam logic [CNT_W-1:0] ONE_C    = CNT_W'(1);

  lintm_mode_t      mode_q, mode_d;
  logic [CNT_W-1:0] mc_cnt_q, mc_cnt_d;   // mode change delay
  logic [CNT_W-1:0] ni_cnt_q, ni_cnt_d;   // normal init delay
  logic [CNT_W-1:0] pw_cnt_q, pw_cnt_d;   // power-up delay
  logic [CNT_W-1:0] dom_cnt_q, dom_cnt_d; // bus dominant length
  logic [CNT_W-1:0] rec_cnt_q, rec_cnt_d; // bus recessive length
  logic [CNT_W-1:0] dto_cnt_q, dto_cnt_d; // txd low length
  logic             txd_q, dto_q, lock_q, wake_q, pw_done_q;
  logic             dto_d, lock_d, wake_d;
  logic             bus_oe_n_q, rx_valid_q, rxd_oe_n_q;

  // bus is a single bit, 0 dominant, 1 recessive
  wire bus_dom     = ~i_bus_in;
  wire in_normal   = (mode_q == LINTM_NORMAL);
  wire low_power   = ~in_normal;
  wire txd_fall    = txd_q & ~i_host.txd;
  wire txd_rise    = ~txd_q & i_host.txd;
  wire dto_expire  = in_normal & ~i_host.txd & ~dto_q & (dto_cnt_q == DOM_TO_C - ONE_C);
  wire bus_qual    = low_power & ~lock_q & bus_dom & (dom_cnt_q == WQ_C - ONE_C);
  wire stuck_hit   = bus_dom & ~lock_q & (dom_cnt_q == STUCK_C - ONE_C);
  wire rearm       = lock_q & ~bus_dom & (rec_cnt_q == CLR_C - ONE_C);
  wire mc_pending  = (mc_cnt_q != '0);
  wire mc_done     = (mc_cnt_q == ONE_C);
  wire rx_valid    = in_normal & pw_done_q & (ni_cnt_q == '0) & ~mc_pending;
  // en request differs from the current mode: start the mode change timer
  wire want_normal = i_host.en & (mode_q != LINTM_NORMAL);
  wire want_sleep  = ~i_host.en & (mode_q == LINTM_NORMAL);

  always_comb begin
    mode_d   = mode_q;
    mc_cnt_d = mc_cnt_q;
    ni_cnt_d = (ni_cnt_q != '0) ? ni_cnt_q - ONE_C : ni_cnt_q;
    if (!mc_pending && (want_normal || want_sleep)) begin
      mc_cnt_d = MC_C;
    end else if (mc_pending && !(want_normal || want_sleep)) begin
      mc_cnt_d = '0;                   // request withdrawn before completion
    end else if (mc_done) begin
      mc_cnt_d = '0;
      if (want_normal) begin
        mode_d   = LINTM_NORMAL;
        ni_cnt_d = NI_C;
      end else begin
        mode_d = LINTM_SLEEP;
      end
    end else if (mc_pending) begin
      mc_cnt_d = mc_cnt_q - ONE_C;
    end
    // qualified bus wake moves sleep to standby, where rxd flags it
    if (bus_qual && mode_q == LINTM_SLEEP && mode_d == LINTM_SLEEP) begin
      mode_d = LINTM_STANDBY;
    end
  end

  always_comb begin
    dom_cnt_d = bus_dom ? ((dom_cnt_q != STUCK_C) ? dom_cnt_q + ONE_C : dom_cnt_q) : '0;
    rec_cnt_d = bus_dom ? '0 : ((rec_cnt_q != CLR_C) ? rec_cnt_q + ONE_C : rec_cnt_q);
    // restart on a falling edge, count while low; a stuck-low txd at reset also counts
    if (!in_normal || i_host.txd || txd_fall) begin
      dto_cnt_d = '0;
    end else begin
      dto_cnt_d = (dto_cnt_q != DOM_TO_C) ? dto_cnt_q + ONE_C : dto_cnt_q;
    end
    dto_d  = (dto_q | dto_expire) & ~txd_rise & in_normal;
    lock_d = (lock_q | stuck_hit) & ~rearm;
    // wake request sticks until normal mode is reached
    wake_d = (wake_q | bus_qual) & ~in_normal;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      mode_q    <= LINTM_SLEEP;
      mc_cnt_q  <= '0;
      ni_cnt_q  <= '0;
      pw_cnt_q  <= '0;
      pw_done_q <= 1'b0;
      dom_cnt_q <= '0;
      rec_cnt_q <= '0;
      dto_cnt_q <= '0;
      txd_q     <= 1'b0;   // txd pulled down when floating
      dto_q     <= 1'b0;
      lock_q    <= 1'b0;
      wake_q    <= 1'b0;
    end else begin
      mode_q    <= mode_d;
      mc_cnt_q  <= mc_cnt_d;
      ni_cnt_q  <= ni_cnt_d;
      pw_cnt_q  <= pw_cnt_d;
      pw_done_q <= pw_done_q | (pw_cnt_q == PWRUP_C - ONE_C);
      dom_cnt_q <= dom_cnt_d;
      rec_cnt_q <= rec_cnt_d;
      dto_cnt_q <= dto_cnt_d;
      txd_q     <= i_host.txd;
      dto_q     <= dto_d;
      lock_q    <= lock_d;
      wake_q    <= wake_d;
    end
  end

  assign pw_cnt_d = pw_done_q ? pw_cnt_q : pw_cnt_q + ONE_C;

  // outputs: open-drain style, oe_n low means pulling low
  wire bus_drive = in_normal & ~i_host.txd & ~dto_q & ~dto_expire;
  wire rxd_next  = in_normal ? (rx_valid ? i_bus_in : 1'b1)
                             : ~(mode_q == LINTM_STANDBY);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      bus_oe_n_q <= 1'b1;
      rx_valid_q <= 1'b0;
      rxd_oe_n_q <= 1'b1;
    end else begin
      bus_oe_n_q <= ~bus_drive;
      // flag moves with rxd on one edge, so the host never sees them split
      rx_valid_q <= rx_valid;
      rxd_oe_n_q <= rxd_next;        // one-cycle path, far faster than 100 kbps
    end
  end

  assign o_bus_oe_n = bus_oe_n_q;
  assign o_rxd_o    = 1'b0;
  assign o_rxd_oe_n = rxd_oe_n_q;
  assign o_mode     = mode_q;
  assign o_stat     = '{dom_timeout: dto_q, wake_lockout: lock_q, rx_valid: rx_valid_q};

  // ---------------- assertions ----------------
  property p_dto_off;
    @(posedge i_clk) disable iff (!i_rst_n)
    dto_q |=> bus_oe_n_q;
  endproperty
  a_dto_off: assert property (p_dto_off) else $error("driver on during timeout");

  property p_dto_clear;
    @(posedge i_clk) disable iff (!i_rst_n)
    (dto_q && txd_rise) |=> !dto_q;
  endproperty
  a_dto_clear: assert property (p_dto_clear) else $error("timeout not cleared");

  property p_dto_len;
    @(posedge i_clk) disable iff (!i_rst_n)
    $rose(dto_q) |-> $past(dto_cnt_q) == DOM_TO_C - ONE_C;
  endproperty
  a_dto_len: assert property (p_dto_len) else $error("timeout at wrong count");

  property p_wake_qual;
    @(posedge i_clk) disable iff (!i_rst_n)
    $rose(wake_q) |-> $past(dom_cnt_q) == WQ_C - ONE_C;
  endproperty
  a_wake_qual: assert property (p_wake_qual) else $error("wake without full dominant");

  property p_rearm;
    @(posedge i_clk) disable iff (!i_rst_n)
    $fell(lock_q) |-> $past(rec_cnt_q) == CLR_C - ONE_C;
  endproperty
  a_rearm: assert property (p_rearm) else $error("lockout cleared early");

  property p_mode_chg;
    @(posedge i_clk) disable iff (!i_rst_n)
    (mc_cnt_q == MC_C && want_normal) ##1 want_normal [*8] |-> ##[0:120] in_normal;
  endproperty
  a_mode_chg: assert property (p_mode_chg) else $error("mode change too slow");

  property p_init;
    @(posedge i_clk) disable iff (!i_rst_n)
    (ni_cnt_q == NI_C && pw_done_q && in_normal) |-> ##[1:600] (rx_valid || !in_normal);
  endproperty
  a_init: assert property (p_init) else $error("rx not valid after init");

  property p_standby_rxd;
    @(posedge i_clk) disable iff (!i_rst_n)
    (mode_q == LINTM_STANDBY) |=> !rxd_oe_n_q;
  endproperty
  a_standby_rxd: assert property (p_standby_rxd) else $error("standby rxd not low");

  property p_rx_follow;
    @(posedge i_clk) disable iff (!i_rst_n)
    rx_valid |=> rxd_oe_n_q == $past(i_bus_in);
  endproperty
  a_rx_follow: assert property (p_rx_follow) else $error("rxd not following bus");

  // before init ends rxd stays released rather than showing stale data
  property p_rx_release;
    @(posedge i_clk) disable iff (!i_rst_n)
    (in_normal && !rx_valid) |=> rxd_oe_n_q;
  endproperty
  a_rx_release: assert property (p_rx_release) else $error("rxd driven before valid");

  property p_sleep_rxd;
    @(posedge i_clk) disable iff (!i_rst_n)
    (mode_q == LINTM_SLEEP) |=> rxd_oe_n_q;
  endproperty
  a_sleep_rxd: assert property (p_sleep_rxd) else $error("rxd driven in sleep");

  // transmit path
  property p_tx_rec;
    @(posedge i_clk) disable iff (!i_rst_n)
    (in_normal && i_host.txd) |=> bus_oe_n_q;
  endproperty
  a_tx_rec: assert property (p_tx_rec) else $error("bus pulled with txd high");

  // the driver follows txd low until the timeout count ends
  property p_tx_low;
    @(posedge i_clk) disable iff (!i_rst_n)
    (in_normal && !i_host.txd && !dto_q && (dto_cnt_q < DOM_TO_C - ONE_C)) |=> !bus_oe_n_q;
  endproperty
  a_tx_low: assert property (p_tx_low) else $error("bus not pulled with txd low");

  property p_sleep_tx;
    @(posedge i_clk) disable iff (!i_rst_n)
    !in_normal |=> bus_oe_n_q;
  endproperty
  a_sleep_tx: assert property (p_sleep_tx) else $error("bus pulled outside normal");

  // leaving normal must drop a pending timeout fault
  property p_dto_normal;
    @(posedge i_clk) disable iff (!i_rst_n)
    !in_normal |=> !dto_q;
  endproperty
  a_dto_normal: assert property (p_dto_normal) else $error("timeout outside normal");

  // mode sequencing
  // mirror of the wake-side check for the drop into sleep
  property p_sleep_chg;
    @(posedge i_clk) disable iff (!i_rst_n)
    (mc_cnt_q == MC_C && want_sleep) ##1 want_sleep [*8] |-> ##[0:120] (mode_q == LINTM_SLEEP);
  endproperty
  a_sleep_chg: assert property (p_sleep_chg) else $error("sleep entry too slow");

  // power-on gate closes exactly once, at the end of its count
  property p_pwrup;
    @(posedge i_clk) disable iff (!i_rst_n)
    $rose(pw_done_q) |-> $past(pw_cnt_q) == PWRUP_C - ONE_C;
  endproperty
  a_pwrup: assert property (p_pwrup) else $error("power-up gate at wrong count");

  // wake and lockout
  // shorter dominant bursts leave a sleeping device asleep
  property p_wake_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
    (mode_q == LINTM_SLEEP && !i_host.en && (dom_cnt_q < WQ_C - ONE_C)) |=> (mode_q == LINTM_SLEEP);
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("early bus wake");

  // lockout only after the full stuck-dominant count
  property p_stuck;
    @(posedge i_clk) disable iff (!i_rst_n)
    $rose(lock_q) |-> $past(dom_cnt_q) == STUCK_C - ONE_C;
  endproperty
  a_stuck: assert property (p_stuck) else $error("lockout at wrong count");

endmodule

// ===== logic/lintm_pkg.sv
// package: timing constants and carrier types for the lin transceiver control logic
package lintm_pkg;

  localparam int unsigned CLK_HZ = 20_000_000;

  // times in their own units, as specified
  localparam int unsigned WAKE_QUAL_MIN_US   = 25;
  localparam int unsigned WAKE_QUAL_MAX_US   = 150;
  localparam int unsigned CLEAR_MIN_US       = 8;
  localparam int unsigned CLEAR_MAX_US       = 50;
  localparam int unsigned DOM_TO_MIN_MS      = 20;
  localparam int unsigned DOM_TO_NOM_MS      = 34;
  localparam int unsigned DOM_TO_MAX_MS      = 80;
  localparam int unsigned MODE_CHG_MIN_US    = 2;
  localparam int unsigned MODE_CHG_MAX_US    = 15;
  localparam int unsigned NORM_INIT_MAX_US   = 30;
  localparam int unsigned PWRUP_MAX_US       = 1500;
  localparam int unsigned STUCK_DOM_MS       = DOM_TO_NOM_MS;

  // chosen operating points: nominal wake qualify, clear in the lower half of its window
  localparam int unsigned WAKE_QUAL_US = 100;
  localparam int unsigned CLEAR_US     = 17;
  localparam int unsigned MODE_CHG_US  = 5;
  localparam int unsigned NORM_INIT_US = 20;
  localparam int unsigned PWRUP_US     = 1000;

  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned WAKE_QUAL_CYC = WAKE_QUAL_US * CYC_PER_US;
  localparam int unsigned CLEAR_CYC     = CLEAR_US * CYC_PER_US;
  localparam int unsigned MODE_CHG_CYC  = MODE_CHG_US * CYC_PER_US;
  localparam int unsigned NORM_INIT_CYC = NORM_INIT_US * CYC_PER_US;
  localparam int unsigned PWRUP_CYC     = PWRUP_US * CYC_PER_US;
  localparam int unsigned DOM_TO_CYC    = DOM_TO_NOM_MS * 1000 * CYC_PER_US;
  localparam int unsigned STUCK_DOM_CYC = STUCK_DOM_MS * 1000 * CYC_PER_US;

  localparam int unsigned CNT_W = 20;

  typedef enum logic [1:0] {
    LINTM_SLEEP,
    LINTM_STANDBY,
    LINTM_NORMAL
  } lintm_mode_t;

  // host-side pins
  typedef struct packed {
    logic txd;
    logic en;
  } lintm_host_in_t;

  // status flags seen by the host
  typedef struct packed {
    logic dom_timeout;
    logic wake_lockout;
    logic rx_valid;
  } lintm_stat_t;

endpackage
